// ===== core/nmi_core.sv
// fine quadrature modulator with interpolation-mode configuration
// assumes clk runs at the converter update rate and the sink accepts one sample a cycle
// What this block does
// - carrier is cosine and sine 90 degrees apart, mixed and summed into I and Q
// - 32-bit tuning word held in four consecutive byte registers, low byte first
// - oscillator steps at input rate, or twice that with first stage on
// - carrier frequency is word over two to the 32 times oscillator rate
// - tuning word applies only on a 0 to 1 edge of update bit 0
// - all other configuration registers act at once when written
// - three consecutive mode registers; 2-bit first, doubled 3-bit second and third
// - four-times mode bypasses the third stage; first two set the shift
// - eight-times mode runs all three stages in cascade
// - premodulation shifts input by half its rate with first-stage mode 1 or 3
// - four-times through second and third stages with first bypassed is allowed
// - first stage modes 1,3 cross-mix; modes 2,3 modulate by stage input rate
// - later stages modes 4-7 modulate; only modes 0 and 4 keep I, Q apart
`timescale 1ns/1ps
module nmi_core
  import nmi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire nmi_iq_t smp_data,
  input wire logic smp_valid,
  output logic smp_ready,
  output nmi_iq_t dac_data,
  output logic dac_valid,
  input wire logic dac_ready
);

  // ----------------------------------------
  // buffer and state
  // ----------------------------------------
  nmi_state_t s_r;
  nmi_state_t s_nxt;
  nmi_iq_t fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  logic hb1_en;
  logic hb2_en;
  logic hb3_en;
  logic [1:0] k23;
  logic [1:0] k_all;
  logic [3:0] mask23;
  logic [3:0] mask_all;
  logic pop_need;
  logic adv;
  logic nco_tick;
  logic cross1;
  logic cross2;
  logic cross3;
  logic signed [2*NMI_SMP_W-1:0] dc_ref;

  nmi_fifo #(
    .W(2*NMI_SMP_W),
    .D(NMI_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data(smp_data),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ----------------------------------------
  // rate decode
  // ----------------------------------------
  assign hb1_en = s_r.ctrl[NMI_CTRL_HB1_EN];
  assign hb2_en = s_r.ctrl[NMI_CTRL_HB2_EN];
  assign hb3_en = s_r.ctrl[NMI_CTRL_HB3_EN];
  assign k23 = 2'(hb2_en) + 2'(hb3_en);
  assign k_all = k23 + 2'(hb1_en);
  assign mask23 = (4'h1 << k23) - 4'h1;
  assign mask_all = (4'h1 << k_all) - 4'h1;
  assign pop_need = (s_r.cnt & mask_all) == 4'h0;
  assign nco_tick = (s_r.cnt & mask23) == 4'h0;
  // stalls when the sink holds off or the buffer runs dry, so back-pressure reaches the source
  assign adv = dac_ready && (!pop_need || fifo_valid);
  assign fifo_pop = dac_ready && pop_need;

  assign cross1 = hb1_en && s_r.hb1[NMI_HB1_CROSS_BIT];
  assign cross2 = hb2_en && (s_r.hb2[1:0] != 2'h0);
  assign cross3 = hb3_en && (s_r.hb3[1:0] != 2'h0);

  assign dac_data = s_r.out;
  assign dac_valid = s_r.out_v;
  assign reg_rdata = s_r.rdata;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nmi_iq_t smp;
    nmi_iq_t car;
    nmi_iq_t mix;
    logic signed [2*NMI_SMP_W:0] acc_i;
    logic signed [2*NMI_SMP_W:0] acc_q;
    smp = '0;
    car = '0;
    mix = '0;
    acc_i = '0;
    acc_q = '0;
    s_nxt = s_r;

    // mode and control bytes take effect immediately
    if (reg_wr) begin
      unique case (reg_addr)
        NMI_ADDR_CTRL: s_nxt.ctrl = reg_wdata[NMI_CTRL_W-1:0];
        NMI_ADDR_HB1: s_nxt.hb1 = reg_wdata[1:0];
        NMI_ADDR_HB2: s_nxt.hb2 = reg_wdata[5:0];
        NMI_ADDR_HB3: s_nxt.hb3 = reg_wdata[5:0];
        // bytes only fill the pending word
        NMI_ADDR_FTW0: s_nxt.ftw_pend[7:0] = reg_wdata;
        NMI_ADDR_FTW1: s_nxt.ftw_pend[15:8] = reg_wdata;
        NMI_ADDR_FTW2: s_nxt.ftw_pend[23:16] = reg_wdata;
        NMI_ADDR_FTW3: s_nxt.ftw_pend[31:24] = reg_wdata;
        NMI_ADDR_UPD: begin
          s_nxt.upd = reg_wdata[NMI_UPD_BIT];
          if (reg_wdata[NMI_UPD_BIT] && !s_r.upd) begin
            s_nxt.ftw_act = s_r.ftw_pend;
          end
        end
        default: ;
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        NMI_ADDR_CTRL: s_nxt.rdata = 8'(s_r.ctrl);
        NMI_ADDR_HB1: s_nxt.rdata = 8'(s_r.hb1);
        NMI_ADDR_HB2: s_nxt.rdata = 8'(s_r.hb2);
        NMI_ADDR_HB3: s_nxt.rdata = 8'(s_r.hb3);
        NMI_ADDR_FTW0: s_nxt.rdata = s_r.ftw_pend[7:0];
        NMI_ADDR_FTW1: s_nxt.rdata = s_r.ftw_pend[15:8];
        NMI_ADDR_FTW2: s_nxt.rdata = s_r.ftw_pend[23:16];
        NMI_ADDR_FTW3: s_nxt.rdata = s_r.ftw_pend[31:24];
        NMI_ADDR_UPD: s_nxt.rdata = 8'(s_r.upd);
        NMI_ADDR_STAT: s_nxt.rdata = {4'h0, s_r.out_v, cross3, cross2, cross1};
        default: s_nxt.rdata = NMI_RD_NONE;
      endcase
    end

    if (adv) begin
      smp = pop_need ? fifo_data : s_r.hold;
      s_nxt.hold = smp;
      // premodulation, alternate sign per input sample
      if (s_r.ctrl[NMI_CTRL_PREMOD] && hb1_en && s_r.hb1[NMI_HB1_CROSS_BIT] && s_r.cnt[k_all]) begin
        smp.i = -smp.i;
        smp.q = -smp.q;
      end
      // first stage modulation by its input rate
      if (hb1_en && s_r.hb1[NMI_HB1_MOD_BIT] && s_r.cnt[k23]) begin
        smp.i = -smp.i;
        smp.q = -smp.q;
      end
      // complex mix; half gain keeps the sum from wrapping
      car = nmi_carrier(s_r.phase[NMI_PHASE_W-1 -: NMI_OCT_W]);
      acc_i = (2*NMI_SMP_W+1)'(smp.i * car.i) - (2*NMI_SMP_W+1)'(smp.q * car.q);
      acc_q = (2*NMI_SMP_W+1)'(smp.i * car.q) + (2*NMI_SMP_W+1)'(smp.q * car.i);
      mix.i = acc_i[2*NMI_SMP_W-1 -: NMI_SMP_W];
      mix.q = acc_q[2*NMI_SMP_W-1 -: NMI_SMP_W];
      if (!s_r.ctrl[NMI_CTRL_NCO_EN]) begin
        mix = smp;
      end
      // later stage modulation by their input rates
      if (hb2_en && s_r.hb2[NMI_MODE_MOD_BIT] && s_r.cnt[hb3_en]) begin
        mix.i = -mix.i;
        mix.q = -mix.q;
      end
      if (hb3_en && s_r.hb3[NMI_MODE_MOD_BIT] && s_r.cnt[0]) begin
        mix.i = -mix.i;
        mix.q = -mix.q;
      end
      if (nco_tick) begin
        s_nxt.phase = s_r.phase + s_r.ftw_act;
      end
      s_nxt.cnt = s_r.cnt + 4'h1;
      s_nxt.out = mix;
      s_nxt.out_v = 1'b1;
    end else if (dac_ready) begin
      s_nxt.out_v = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_ftw_rise;
    ce && reg_wr && reg_addr == NMI_ADDR_UPD && reg_wdata[NMI_UPD_BIT] && !s_r.upd;
  endsequence

  sequence s_ftw_byte;
    ce && reg_wr && reg_addr >= NMI_ADDR_FTW0 && reg_addr <= NMI_ADDR_FTW3;
  endsequence

  a_ftw_apply_edge: assert property (@(posedge clk) disable iff (!rst_n)
    s_ftw_rise |=> s_r.ftw_act == $past(s_r.ftw_pend))
    else $error("tuning word not applied on update edge");

  a_ftw_byte_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_ftw_byte |=> $stable(s_r.ftw_act))
    else $error("tuning byte write changed active word");

  a_ftw_byte_lane: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == NMI_ADDR_FTW3 |=> s_r.ftw_pend[31:24] == $past(reg_wdata))
    else $error("top tuning byte not stored");

  a_mode_immediate: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == NMI_ADDR_HB2 |=> s_r.hb2 == $past(reg_wdata[5:0]))
    else $error("mode write not immediate");

  a_phase_step: assert property (@(posedge clk) disable iff (!rst_n)
    ce && adv && nco_tick |=> s_r.phase == $past(s_r.phase) + $past(s_r.ftw_act))
    else $error("phase accumulator step wrong");

  a_nco_rate_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ce && adv && !nco_tick |=> $stable(s_r.phase))
    else $error("oscillator stepped off its rate");

  a_rate_eight: assert property (@(posedge clk) disable iff (!rst_n)
    ce && hb1_en && hb2_en && hb3_en && fifo_pop && fifo_valid |-> s_r.cnt[2:0] == 3'h0)
    else $error("input taken off the eight-times grid");

  a_rate_four: assert property (@(posedge clk) disable iff (!rst_n)
    ce && hb1_en && hb2_en && !hb3_en && fifo_pop && fifo_valid |-> s_r.cnt[1:0] == 2'h0)
    else $error("input taken off the four-times grid");

  // zero-phase carrier is just under full scale, so the product is not a plain halving
  assign dc_ref = 32'(fifo_data.i) * 32'sh0000_7FFF;

  a_mix_dc: assert property (@(posedge clk) disable iff (!rst_n)
    ce && adv && s_r.ctrl == NMI_CTRL_W'(1 << NMI_CTRL_NCO_EN) && s_r.phase[31:29] == 3'h0
    && pop_need |=> s_r.out.i == $past(dc_ref[31:16]))
    else $error("zero-phase mix not half gain");

  a_cross_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_rd && reg_addr == NMI_ADDR_STAT |=> s_r.rdata[1] == $past(cross2))
    else $error("cross-mix status wrong");

  a_cross_third: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_rd && reg_addr == NMI_ADDR_STAT |=> s_r.rdata[2] == $past(cross3))
    else $error("third-stage cross-mix status wrong");

  // premod slot: first stage mode 1 alone, oscillator off
  sequence s_premod_slot;
    ce && adv && pop_need && s_r.hb1 == 2'h1
    && s_r.ctrl == NMI_CTRL_W'((1 << NMI_CTRL_HB1_EN) | (1 << NMI_CTRL_PREMOD));
  endsequence

  a_premod_sign: assert property (@(posedge clk) disable iff (!rst_n)
    s_premod_slot |=> s_r.out.i == ($past(s_r.cnt[1]) ? -$past(fifo_data.i)
    : $past(fifo_data.i)))
    else $error("premodulation sign wrong");

  a_hb1_modulate: assert property (@(posedge clk) disable iff (!rst_n)
    ce && adv && !pop_need && s_r.hb1 == 2'h2 && s_r.ctrl == NMI_CTRL_W'(1 << NMI_CTRL_HB1_EN)
    |=> s_r.out.i == -$past(s_r.hold.i))
    else $error("first stage modulation sign wrong");

  a_stage2_modulate: assert property (@(posedge clk) disable iff (!rst_n)
    ce && adv && s_r.cnt[0] && s_r.hb1 == 2'h0 && s_r.hb2[NMI_MODE_MOD_BIT]
    && s_r.ctrl == NMI_CTRL_W'((1 << NMI_CTRL_HB1_EN) | (1 << NMI_CTRL_HB2_EN))
    |=> s_r.out.i == -$past(s_r.hold.i))
    else $error("second stage modulation sign wrong");

  a_rate_low_power: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !hb1_en && hb2_en && hb3_en && fifo_pop && fifo_valid |-> s_r.cnt[1:0] == 2'h0)
    else $error("input taken off the low-power four-times grid");

  a_ftw_no_rearm: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == NMI_ADDR_UPD && s_r.upd |=> $stable(s_r.ftw_act))
    else $error("tuning word applied without a rising update");

  a_upd_stored: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == NMI_ADDR_UPD |=> s_r.upd == $past(reg_wdata[NMI_UPD_BIT]))
    else $error("update bit not stored");

  a_hb1_immediate: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == NMI_ADDR_HB1 |=> s_r.hb1 == $past(reg_wdata[1:0]))
    else $error("first stage mode write not immediate");

  a_hb3_immediate: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == NMI_ADDR_HB3 |=> s_r.hb3 == $past(reg_wdata[5:0]))
    else $error("third stage mode write not immediate");

  a_ctrl_immediate: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == NMI_ADDR_CTRL
    |=> s_r.ctrl == $past(reg_wdata[NMI_CTRL_W-1:0]))
    else $error("control write not immediate");
endmodule

// ===== core/nmi_fifo.sv
// sample buffer between the baseband source and the modulator datapath
// assumes both sides on clk; ce low freezes it
`timescale 1ns/1ps
module nmi_fifo
  import nmi_pkg::*;
#(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } nmi_fifo_st_t;

  nmi_fifo_st_t s_r;
  nmi_fifo_st_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = (s_r.cnt != (AW+1)'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  a_fifo_count: assert property (@(posedge clk) disable iff (!rst_n)
    ce && push && !pop |=> s_r.cnt == $past(s_r.cnt) + 1'b1)
    else $error("fifo count did not rise on push");
endmodule

// ===== core/nmi_pkg.sv
// package for the oscillator, mixer and interpolation-mode configuration block
// assumes an 8-bit register port and one clock at the converter update rate
package nmi_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] NMI_ADDR_CTRL = 8'h1B;
  localparam logic [7:0] NMI_ADDR_HB1 = 8'h1C;
  localparam logic [7:0] NMI_ADDR_HB2 = 8'h1D;
  localparam logic [7:0] NMI_ADDR_HB3 = 8'h1E;
  localparam logic [7:0] NMI_ADDR_FTW0 = 8'h30;
  localparam logic [7:0] NMI_ADDR_FTW1 = 8'h31;
  localparam logic [7:0] NMI_ADDR_FTW2 = 8'h32;
  localparam logic [7:0] NMI_ADDR_FTW3 = 8'h33;
  localparam logic [7:0] NMI_ADDR_UPD = 8'h36;
  localparam logic [7:0] NMI_ADDR_STAT = 8'h37;

  // ----------------------------------------
  // field layouts, sizes and the unmapped read value
  // ----------------------------------------
  localparam int NMI_CTRL_HB1_EN = 0;
  localparam int NMI_CTRL_HB2_EN = 1;
  localparam int NMI_CTRL_HB3_EN = 2;
  localparam int NMI_CTRL_PREMOD = 3;
  localparam int NMI_CTRL_NCO_EN = 4;
  localparam int NMI_CTRL_W = 5;
  localparam int NMI_UPD_BIT = 0;
  localparam int NMI_MODE_MOD_BIT = 2;
  localparam int NMI_HB1_MOD_BIT = 1;
  localparam int NMI_HB1_CROSS_BIT = 0;
  localparam int NMI_FIFO_DEPTH = 16;
  localparam int NMI_SMP_W = 16;
  localparam int NMI_PHASE_W = 32;
  localparam int NMI_OCT_W = 3;
  localparam logic [7:0] NMI_RD_NONE = 8'h00;

  // ----------------------------------------
  // carried types
  // ----------------------------------------
  typedef struct packed {
    logic signed [NMI_SMP_W-1:0] i;
    logic signed [NMI_SMP_W-1:0] q;
  } nmi_iq_t;

  typedef struct packed {
    logic [1:0] hb1;
    logic [5:0] hb2;
    logic [5:0] hb3;
    logic [NMI_CTRL_W-1:0] ctrl;
    logic [NMI_PHASE_W-1:0] ftw_pend;
    logic upd;
    logic [NMI_PHASE_W-1:0] ftw_act;
    logic [NMI_PHASE_W-1:0] phase;
    logic [3:0] cnt;
    nmi_iq_t hold;
    nmi_iq_t out;
    logic out_v;
    logic [7:0] rdata;
  } nmi_state_t;

  // coarse octant carrier table, full scale just under one
  function automatic nmi_iq_t nmi_carrier(input logic [NMI_OCT_W-1:0] oct);
    nmi_iq_t c;
    unique case (oct)
      3'h0: c = '{16'h7FFF, 16'h0000};
      3'h1: c = '{16'h5A82, 16'h5A82};
      3'h2: c = '{16'h0000, 16'h7FFF};
      3'h3: c = '{16'hA57E, 16'h5A82};
      3'h4: c = '{16'h8001, 16'h0000};
      3'h5: c = '{16'hA57E, 16'hA57E};
      3'h6: c = '{16'h0000, 16'h8001};
      3'h7: c = '{16'h5A82, 16'hA57E};
    endcase
    return c;
  endfunction

endpackage

// ===== testbench/nmi_src_model.sv
// baseband source model feeding the sample port
// assumes the block's clock; valid and data held until taken
`timescale 1ns/1ps
module nmi_src_model
  import nmi_pkg::*;
(
  input wire logic clk,
  input wire logic smp_ready,
  output nmi_iq_t smp_data,
  output logic smp_valid
);
  int sent = 0;
  initial begin
    smp_valid = 1'b0;
    smp_data = '0;
  end
  // ----
  // one burst, i field steps by inc
  // ----
  task automatic send(input int n, input nmi_iq_t s, input logic [15:0] inc);
    logic r;
    @(posedge clk);
    #2;
    for (int k = 0; k < n; k++) begin
      smp_data = s;
      smp_valid = 1'b1;
      // ready looked at mid-cycle, so the edge decides without a race
      do begin
        @(negedge clk);
        r = smp_ready;
        @(posedge clk);
      end while (r !== 1'b1);
      #2;
      sent++;
      s.i = s.i + inc;
    end
    smp_valid = 1'b0;
    // released data must not keep looking valid
    smp_data = ~smp_data;
  endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the modulator and interpolation-mode block
// assumes the source model drives samples; the bench is the sink
`timescale 1ns/1ps
module testbench
  import nmi_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  nmi_iq_t smp_data;
  logic smp_valid;
  logic smp_ready;
  nmi_iq_t dac_data;
  logic dac_valid;
  logic dac_ready = 1'b1;
  int failures = 0;
  int tests_run = 0;
  int chg;
  int bad;
  int wn;
  int s0;
  logic [15:0] last;
  logic [7:0] ra [8] = '{NMI_ADDR_HB1, NMI_ADDR_HB2, NMI_ADDR_HB3, NMI_ADDR_FTW0,
    NMI_ADDR_FTW1, NMI_ADDR_FTW2, NMI_ADDR_FTW3, NMI_ADDR_CTRL};
  logic [7:0] rw [8] = '{8'h03, 8'h09, 8'h2D, 8'h12, 8'h34, 8'h56, 8'h78, 8'h1F};
  // ctrl, modes, sign flips expected in eight outputs
  logic [39:0] mt [9] = '{40'h00_00_00_00_00, 40'h01_00_00_00_00, 40'h01_02_00_00_07,
    40'h09_01_00_00_03, 40'h09_00_00_00_00, 40'h03_00_24_00_07, 40'h03_00_09_00_00,
    40'h07_00_00_2D_07, 40'h06_00_00_24_07};
  always #25 clk = ~clk;
  nmi_core dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .smp_data(smp_data),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .dac_data(dac_data),
    .dac_valid(dac_valid), .dac_ready(dac_ready));
  nmi_src_model src_u (.clk(clk), .smp_ready(smp_ready), .smp_data(smp_data),
    .smp_valid(smp_valid));
  // ----
  // access and compare tasks
  // ----
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick();
    reg_rd = 1'b1;
    reg_addr = a;
    tick();
    reg_rd = 1'b0;
    chk8(reg_rdata, exp);
  endtask
  task automatic cfg(input logic [31:0] c);
    wr(NMI_ADDR_HB1, c[23:16]);
    wr(NMI_ADDR_HB2, c[15:8]);
    wr(NMI_ADDR_HB3, c[7:0]);
    wr(NMI_ADDR_CTRL, c[31:24]);
  endtask
  task automatic drain();
    wn = 0;
    while ((smp_valid === 1'b1 || dac_valid === 1'b1) && wn < 600) begin
      tick();
      wn++;
    end
  endtask
  // held input, eight outputs: count sign flips and stray values
  task automatic measure(input logic [15:0] vi, input logic [15:0] p, input logic [15:0] m);
    chg = 0;
    bad = 0;
    wn = 0;
    fork
      src_u.send(24, {vi, 16'h0000}, 16'h0000);
    join_none
    while (dac_valid !== 1'b1 && wn < 40) begin
      tick();
      wn++;
    end
    last = dac_data.i;
    for (int k = 0; k < 8; k++) begin
      if (dac_valid !== 1'b1 || dac_data.q !== 16'h0000) bad++;
      if (dac_data.i !== p && dac_data.i !== m) bad++;
      if (dac_data.i !== last) chg++;
      last = dac_data.i;
      tick();
    end
    drain();
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    for (int k = 0; k < 8; k++) rd(ra[k], 8'h00);
    for (int k = 0; k < 8; k++) wr(ra[k], rw[k]);
    for (int k = 0; k < 8; k++) rd(ra[k], rw[k]);
    wr(8'h40, 8'hA5);
    rd(8'h40, NMI_RD_NONE);
    cfg(32'h07_01_24_09);
    rd(NMI_ADDR_STAT, 8'h05);
    // clock enable low: the write must be lost
    ce = 1'b0;
    wr(NMI_ADDR_HB1, 8'h02);
    ce = 1'b1;
    rd(NMI_ADDR_HB1, 8'h01);
    $display("test registers done");
    for (int k = 0; k < 9; k++) begin
      cfg(mt[k][39:8]);
      measure(16'h1000, 16'h1000, 16'hF000);
      chk_n(bad, 0);
      chk_n(chg, int'(mt[k][7:0]));
    end
    $display("test modes done");
    cfg(32'h10_00_00_00);
    measure(16'h4000, 16'h1FFF, 16'hE000);
    chk_n(bad, 0);
    wr(NMI_ADDR_FTW0, 8'h00);
    wr(NMI_ADDR_FTW1, 8'h00);
    wr(NMI_ADDR_FTW2, 8'h00);
    wr(NMI_ADDR_FTW3, 8'h80);
    measure(16'h4000, 16'h1FFF, 16'hE000);
    chk_n(chg, 0);
    wr(NMI_ADDR_UPD, 8'h01);
    measure(16'h4000, 16'h1FFF, 16'hE000);
    chk_n(bad, 0);
    chk_n(chg, 7);
    cfg(32'h11_00_00_00);
    measure(16'h4000, 16'h1FFF, 16'hE000);
    chk_n(chg, 7);
    cfg(32'h13_00_00_00);
    measure(16'h4000, 16'h1FFF, 16'hE000);
    chk_n(int'(chg inside {3, 4}), 1);
    cfg(32'h11_00_00_00);
    wr(NMI_ADDR_FTW3, 8'h00);
    wr(NMI_ADDR_UPD, 8'h01);
    measure(16'h4000, 16'h1FFF, 16'hE000);
    chk_n(chg, 7);
    wr(NMI_ADDR_UPD, 8'h00);
    wr(NMI_ADDR_UPD, 8'h01);
    measure(16'h4000, 16'h1FFF, 16'hE000);
    chk_n(chg, 0);
    rd(NMI_ADDR_UPD, 8'h01);
    $display("test oscillator done");
    // stalled sink: buffer must refuse after sixteen, then drain in order
    cfg(32'h00_00_00_00);
    dac_ready = 1'b0;
    s0 = src_u.sent;
    fork
      src_u.send(20, 32'h0100_0000, 16'h0001);
    join_none
    repeat (24) tick();
    chk_n(src_u.sent - s0, NMI_FIFO_DEPTH);
    chk8({7'h00, smp_ready}, 8'h00);
    chk8({7'h00, dac_valid}, 8'h00);
    dac_ready = 1'b1;
    bad = 0;
    for (int k = 0; k < 20; k++) begin
      wn = 0;
      while (dac_valid !== 1'b1 && wn < 20) begin
        tick();
        wn++;
      end
      if (dac_data.i !== 16'h0100 + k[15:0]) bad++;
      tick();
    end
    chk_n(bad, 0);
    $display("test buffer done");
    tally_and_finish();
  end
  // about thirty times the expected run, well under the cycle budget
  initial begin
    #2000000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
